// file: rtl/mmbc_regs.svh
`ifndef MMBC_REGS_SVH
`define MMBC_REGS_SVH

// queue state codes, driven the cycle after the queue operation
`define MMBC_QS_NOP 2'h0
`define MMBC_QS_FIRST 2'h1
`define MMBC_QS_FLUSH 2'h2
`define MMBC_QS_NEXT 2'h3

// bus cycle kinds requested by the core
`define MMBC_KIND_MEM_RD 3'h0
`define MMBC_KIND_MEM_WR 3'h1
`define MMBC_KIND_IO_RD 3'h2
`define MMBC_KIND_IO_WR 3'h3
`define MMBC_KIND_IRQ_ACK_STROBE_N 3'h4

// half-state phases: t1, t2, t3, each wait and t4 last two core clocks, t4 only one when hold is granted
`define MMBC_PH_FIRST 1'b0
`define MMBC_PH_SECOND 1'b1

// strap level that selects minimum mode
`define MMBC_STRAP_MIN 1'b1

`endif

// file: rtl/mmbc_pkg.sv
package mmbc_pkg;

   // gray codes along idle, t1, t2, t3, wait, t4
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_T1 = 3'h1,
      ST_T2 = 3'h3,
      ST_T3 = 3'h2,
      ST_TW = 3'h6,
      ST_T4 = 3'h7,
      ST_HOLD = 3'h5
   } mmbc_bstate_t;

   typedef struct packed {
      logic valid;
      logic [2:0] kind;
      logic pairFirst;
   } mmbc_req_t;

   typedef struct packed {
      logic memIoSel;
      logic memIoSelOe;
      logic storeStrobe_n;
      logic storeStrobeOe;
      logic irqAckStrobe_n;
      logic addrLatchPulse;
      logic xcvrDirection;
      logic xcvrDirectionOe;
      logic xcvrOutputEnable_n;
      logic xcvrOutputEnableOe;
      logic busYieldGrant;
   } mmbc_pins_t;

   typedef struct packed {
      mmbc_bstate_t bstate;
      logic phase;
      logic minMode;
      logic floated;
      logic [2:0] curKind;
      logic [2:0] nxtKind;
      logic [2:0] driveKind;
      logic nxtPend;
      logic nxtPair;
      logic pairLock;
      logic reqTaken;
      logic [1:0] qsCode;
      mmbc_pins_t pins;
   } mmbc_state_t;

endpackage : mmbc_pkg

// file: rtl/mmbc_bus_control.sv
`timescale 1ns/1ps
`include "mmbc_regs.svh"

module mmbc_bus_control
   import mmbc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // configuration strap, caught while reset is held
   input wire logic configStrap,
   // core side: cycle requests and queue activity
   input wire mmbc_req_t cpuReq,
   output logic reqTaken,
   input wire logic [1:0] queueOp,
   // memory side: ready, low inserts wait states
   input wire logic memReady,
   // competing master
   input wire logic busYieldReq,
   // queue state pins
   output logic queueStateCodeHi,
   output logic queueStateCodeLo,
   // bus control pins with output enables
   output mmbc_pins_t busPins,
   // current bus state, for observation
   output mmbc_bstate_t busState
);

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------

   function automatic logic isWrite(input logic [2:0] kind);
      isWrite = (kind == `MMBC_KIND_MEM_WR) || (kind == `MMBC_KIND_IO_WR);
   endfunction : isWrite

   function automatic logic isMem(input logic [2:0] kind);
      isMem = (kind == `MMBC_KIND_MEM_RD) || (kind == `MMBC_KIND_MEM_WR);
   endfunction : isMem

   function automatic logic isInta(input logic [2:0] kind);
      isInta = (kind == `MMBC_KIND_IRQ_ACK_STROBE_N);
   endfunction : isInta

   function automatic logic inStrobeState(input mmbc_bstate_t st);
      inStrobeState = (st == ST_T2) || (st == ST_T3) || (st == ST_TW);
   endfunction : inStrobeState

   // ----------------------------------------------------------------
   // pin derivation from the next state
   // ----------------------------------------------------------------

   // pins are computed from the next state so they leave flip-flops
   // aligned with the state they belong to
   function automatic mmbc_pins_t pinsOf(input mmbc_state_t s);
      mmbc_pins_t p;
      logic drive;
      logic denOn;
      p = '0;
      drive = 1'b0;
      denOn = 1'b0;
      p.storeStrobe_n = 1'b1;
      p.irqAckStrobe_n = 1'b1;
      p.xcvrOutputEnable_n = 1'b1;
      if (s.minMode == `MMBC_STRAP_MIN) begin
         drive = !s.floated;
         // space select of the upcoming or running cycle
         p.memIoSel = isMem(s.driveKind);
         p.memIoSelOe = drive;
         p.xcvrDirection = isWrite(s.driveKind);
         p.xcvrDirectionOe = drive;
         // store strobe in t2, t3, waits
         p.storeStrobe_n = !(isWrite(s.curKind) && inStrobeState(s.bstate));
         p.storeStrobeOe = drive;
         p.irqAckStrobe_n = !(isInta(s.curKind) && inStrobeState(s.bstate));
         // latch pulse in t1, never floated
         p.addrLatchPulse = (s.bstate == ST_T1);
         case (s.bstate)
            ST_T2: begin
               // write from start of t2, read from mid t2
               denOn = isWrite(s.curKind) || (s.phase == `MMBC_PH_SECOND);
            end
            ST_T3, ST_TW: begin
               denOn = 1'b1;
            end
            ST_T4: begin
               // ends mid t4 for all kinds
               denOn = (s.phase == `MMBC_PH_FIRST);
            end
            default: begin
               denOn = 1'b0;
            end
         endcase
         p.xcvrOutputEnable_n = !denOn;
         p.xcvrOutputEnableOe = drive;
         p.busYieldGrant = (s.bstate == ST_HOLD);
      end
      pinsOf = p;
   endfunction : pinsOf

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------

   mmbc_state_t s_q;
   mmbc_state_t s_d;

   localparam mmbc_state_t RESET_STATE = '{
      bstate: ST_IDLE,
      phase: `MMBC_PH_FIRST,
      minMode: 1'b0,
      floated: 1'b0,
      curKind: `MMBC_KIND_MEM_RD,
      nxtKind: `MMBC_KIND_MEM_RD,
      driveKind: `MMBC_KIND_MEM_RD,
      nxtPend: 1'b0,
      nxtPair: 1'b0,
      pairLock: 1'b0,
      reqTaken: 1'b0,
      qsCode: `MMBC_QS_NOP,
      pins: '{
         memIoSel: 1'b0,
         memIoSelOe: 1'b0,
         storeStrobe_n: 1'b1,
         storeStrobeOe: 1'b0,
         irqAckStrobe_n: 1'b1,
         addrLatchPulse: 1'b0,
         xcvrDirection: 1'b0,
         xcvrDirectionOe: 1'b0,
         xcvrOutputEnable_n: 1'b1,
         xcvrOutputEnableOe: 1'b0,
         busYieldGrant: 1'b0
      }
   };

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------

   always_comb begin
      logic canTake;
      logic yieldOk;
      canTake = 1'b0;
      yieldOk = 1'b0;
      s_d = s_q;
      s_d.reqTaken = 1'b0;
      s_d.phase = !s_q.phase;
      // registered, so it shows one cycle after the operation
      s_d.qsCode = queueOp;
      // hold handshake only exists in minimum mode
      // no release inside an odd-address word pair
      yieldOk = (s_q.minMode == `MMBC_STRAP_MIN) && busYieldReq &&
                !s_q.pairLock;

      case (s_q.bstate)
         ST_IDLE: begin
            if (s_q.phase == `MMBC_PH_FIRST) begin
               if (yieldOk) begin
                  // grant rises in the middle of idle
                  // lines float at the same moment
                  s_d.bstate = ST_HOLD;
                  s_d.floated = 1'b1;
               end else begin
                  canTake = !s_q.nxtPend;
               end
            end else if (s_q.nxtPend) begin
               s_d.bstate = ST_T1;
            end
         end
         ST_T1: begin
            if (s_q.phase == `MMBC_PH_SECOND) begin
               s_d.bstate = ST_T2;
            end
         end
         ST_T2: begin
            if (s_q.phase == `MMBC_PH_SECOND) begin
               s_d.bstate = ST_T3;
            end
         end
         ST_T3, ST_TW: begin
            if (s_q.phase == `MMBC_PH_SECOND) begin
               // ready sampled at the end of t3 or each wait
               if (memReady) begin
                  s_d.bstate = ST_T4;
                  // next cycle's select is set at t4 entry
                  canTake = !s_q.nxtPend;
               end else begin
                  s_d.bstate = ST_TW;
               end
            end
         end
         ST_T4: begin
            if (s_q.phase == `MMBC_PH_FIRST) begin
               if (yieldOk) begin
                  // grant rises in the middle of t4
                  // lines float at the same moment
                  s_d.bstate = ST_HOLD;
                  s_d.floated = 1'b1;
               end
            end else if (s_q.nxtPend) begin
               s_d.bstate = ST_T1;
            end else begin
               s_d.bstate = ST_IDLE;
            end
         end
         ST_HOLD: begin
            // request seen low lowers the grant, lines stay off
            if (s_q.phase == `MMBC_PH_SECOND && !busYieldReq) begin
               s_d.bstate = ST_IDLE;
            end
         end
         default: begin
            s_d.bstate = ST_IDLE;
         end
      endcase

      // accept the next cycle request
      if (canTake && cpuReq.valid) begin
         s_d.nxtPend = 1'b1;
         s_d.nxtKind = cpuReq.kind;
         s_d.nxtPair = cpuReq.pairFirst;
         s_d.driveKind = cpuReq.kind;
         s_d.reqTaken = 1'b1;
         // drive again only once a cycle is needed
         s_d.floated = 1'b0;
      end

      // cycle start: pending request becomes the running one
      if (s_d.bstate == ST_T1 && s_q.bstate != ST_T1) begin
         s_d.curKind = s_q.nxtKind;
         s_d.nxtPend = 1'b0;
         // lock holds until the second half has started
         s_d.pairLock = s_q.nxtPair;
         // a cycle left pending across a hold drives again here
         s_d.floated = 1'b0;
      end

      s_d.pins = pinsOf(s_d);
   end

   // ----------------------------------------------------------------
   // register
   // ----------------------------------------------------------------

   // strap is caught by the clock while reset is held
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         s_q <= RESET_STATE;
         s_q.minMode <= configStrap;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------

   assign reqTaken = s_q.reqTaken;
   assign queueStateCodeHi = s_q.qsCode[1];
   assign queueStateCodeLo = s_q.qsCode[0];
   assign busPins = s_q.pins;
   assign busState = s_q.bstate;

endmodule : mmbc_bus_control

// file: tb/mmbc_bus_control_monitor.sv
`timescale 1ns/1ps
module mmbc_bus_control_monitor
   import mmbc_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // watched ports
   input wire logic configStrap,
   input wire logic reqTaken,
   input wire logic [1:0] queueOp,
   input wire logic busYieldReq,
   input wire logic queueStateCodeHi,
   input wire logic queueStateCodeLo,
   input wire mmbc_pins_t busPins,
   input wire mmbc_bstate_t busState
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // --------
   // checks
   // --------
   chk_qs_delay: assert property (
      !$past(sys_rst) |->
      {queueStateCodeHi, queueStateCodeLo} == $past(queueOp))
      else $error("queue code lag wrong");
   chk_ale_in_t1: assert property (
      busPins.addrLatchPulse |-> busState == ST_T1)
      else $error("latch pulse outside t1");
   chk_ale_width: assert property (
      $rose(busPins.addrLatchPulse) |-> busPins.addrLatchPulse
      ##1 busPins.addrLatchPulse ##1 !busPins.addrLatchPulse)
      else $error("latch pulse width wrong");
   chk_store_window: assert property (
      !busPins.storeStrobe_n && busPins.storeStrobeOe |->
      busState inside {ST_T2, ST_T3, ST_TW} && busPins.xcvrDirection)
      else $error("store strobe misplaced");
   chk_ack_window: assert property (
      !busPins.irqAckStrobe_n |-> busState inside {ST_T2, ST_T3, ST_TW})
      else $error("ack strobe misplaced");
   chk_den_window: assert property (
      !busPins.xcvrOutputEnable_n && busPins.xcvrOutputEnableOe |->
      busState inside {ST_T2, ST_T3, ST_TW, ST_T4})
      else $error("enable outside t2..t4");
   chk_grant_float: assert property (
      $rose(busPins.busYieldGrant) |-> !(busPins.memIoSelOe |
      busPins.storeStrobeOe | busPins.xcvrDirectionOe |
      busPins.xcvrOutputEnableOe))
      else $error("lines driven at grant");
   chk_grant_point: assert property (
      $rose(busPins.busYieldGrant) |-> $past(busState) inside {ST_T4, ST_IDLE})
      else $error("grant outside t4 or idle");
   chk_grant_drop: assert property (
      $fell(busYieldReq) && busPins.busYieldGrant |->
      ##[1:4] !busPins.busYieldGrant)
      else $error("grant not lowered");
   chk_taken_pulse: assert property (
      reqTaken |=> !reqTaken)
      else $error("taken pulse too long");
   chk_max_mode: assert property (
      !configStrap |-> !busPins.addrLatchPulse &&
      !busPins.busYieldGrant && !busPins.memIoSelOe)
      else $error("min pins active in max mode");
   chk_drive_in_t1: assert property (
      configStrap && busState == ST_T1 |->
      busPins.memIoSelOe && busPins.xcvrOutputEnableOe)
      else $error("lines floated during a cycle");
   cov_hold: cover property (busPins.busYieldGrant);
   cov_wait: cover property (busState == ST_TW);
   cov_store: cover property (!busPins.storeStrobe_n);
endmodule : mmbc_bus_control_monitor

bind mmbc_bus_control mmbc_bus_control_monitor i_mmbc_bus_control_monitor (
   .core_clk, .sys_rst, .configStrap, .reqTaken, .queueOp, .busYieldReq,
   .queueStateCodeHi, .queueStateCodeLo, .busPins, .busState);

// file: tb/mmbc_far_end.sv
`timescale 1ns/1ps
module mmbc_far_end
   import mmbc_pkg::*;
(
   // clock and controls
   input wire logic core_clk,
   input wire logic holdOn,
   input wire logic [1:0] waitCnt,
   // device side
   input wire mmbc_pins_t busPins,
   output logic memReady,
   output logic busYieldReq = 1'b0,
   output logic [7:0] latchCnt = 8'h0
);
   logic aleQ = 1'b0;
   logic [3:0] cnt = 4'h0;
   // ready held low to insert waitCnt waits
   assign memReady = (cnt == 4'h0);
   always @(posedge core_clk) begin
      busYieldReq <= holdOn;
      aleQ <= busPins.addrLatchPulse;
      if (aleQ && !busPins.addrLatchPulse) begin
         cnt <= 4'h2 + {1'b0, waitCnt, 1'b0};
         latchCnt <= latchCnt + 8'h1;
      end else if (cnt != 4'h0) begin
         cnt <= cnt - 4'h1;
      end
   end
endmodule : mmbc_far_end

// file: tb/mmbc_bus_control_bench.sv
`timescale 1ns/1ps
module mmbc_bus_control_bench
   import mmbc_pkg::*;
();
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic configStrap = 1'b1;
   mmbc_req_t cpuReq = '0;
   logic [1:0] queueOp = 2'h0;
   logic holdOn = 1'b0;
   logic [1:0] waitCnt = 2'h0;
   logic reqTaken, memReady, busYieldReq;
   logic queueStateCodeHi, queueStateCodeLo;
   mmbc_pins_t busPins;
   mmbc_bstate_t busState;
   logic [7:0] latchCnt;
   int error_cnt = 0;
   int num_checks = 0;
   always #25 core_clk = ~core_clk;
   mmbc_bus_control i_mmbc_bus_control (.core_clk, .sys_rst, .configStrap,
      .cpuReq, .reqTaken, .queueOp, .memReady, .busYieldReq,
      .queueStateCodeHi, .queueStateCodeLo, .busPins, .busState);
   mmbc_far_end i_mmbc_far_end (.core_clk, .holdOn, .waitCnt, .busPins,
      .memReady, .busYieldReq, .latchCnt);
   // --------
   // tasks
   // --------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic bound(input int n);
      if (n >= 40) begin
         chk(8'h1, 8'h0);
         end_of_test();
      end
   endtask : bound
   task automatic do_reset(input logic strap);
      sys_rst = 1'b1;
      configStrap = strap;
      repeat (16) @(negedge core_clk);
      sys_rst = 1'b0;
   endtask : do_reset
   task automatic take(input logic [2:0] kind, input logic pair);
      int n = 0;
      cpuReq = '{1'b1, kind, pair};
      while (!reqTaken && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      bound(n);
      cpuReq.valid = 1'b0;
   endtask : take
   task automatic run_cycle(input logic [2:0] kind, input logic pair,
      input logic [1:0] w, input logic h);
      logic [7:0] st = 8'h0;
      logic [7:0] ak = 8'h0;
      logic [7:0] xcvr_output_enable_n = 8'h0;
      logic [7:0] lat = latchCnt;
      int n = 0;
      waitCnt = w;
      take(kind, pair);
      holdOn = h;
      if (kind != 3'h4) chk(8'(busPins.memIoSel), 8'(!kind[1]));
      chk(8'(busPins.xcvrDirection), 8'(kind[0]));
      chk(8'(busPins.memIoSelOe), 8'h1);
      @(negedge core_clk);
      while (!(busState inside {ST_IDLE, ST_HOLD}) && n < 40) begin
         st += 8'(!busPins.storeStrobe_n);
         ak += 8'(!busPins.irqAckStrobe_n);
         xcvr_output_enable_n += 8'(!busPins.xcvrOutputEnable_n);
         @(negedge core_clk);
         n++;
      end
      bound(n);
      chk(st, kind[0] ? 8'(4 + 2 * w) : 8'h0);
      chk(ak, kind[2] ? 8'(4 + 2 * w) : 8'h0);
      chk(xcvr_output_enable_n, 8'(4 + 2 * w + kind[0]));
      chk(latchCnt - lat, 8'h1);
   endtask : run_cycle
   task automatic test_queue();
      for (int k = 0; k < 4; k++) begin
         queueOp = 2'(k);
         @(negedge core_clk);
         queueOp = 2'h0;
         chk(8'({queueStateCodeHi, queueStateCodeLo}), 8'(k));
      end
      $display("queue test done");
   endtask : test_queue
   task automatic test_cycles();
      for (int k = 0; k < 5; k++) begin
         run_cycle(3'(k), 1'b0, 2'(k % 3), 1'b0);
      end
      $display("cycle test done");
   endtask : test_cycles
   task automatic test_hold();
      int n = 0;
      run_cycle(3'h0, 1'b1, 2'h0, 1'b1);
      repeat (4) begin
         @(negedge core_clk);
         chk(8'(busPins.busYieldGrant), 8'h0);
      end
      run_cycle(3'h0, 1'b0, 2'h0, 1'b1);
      chk(8'(busPins.busYieldGrant), 8'h1);
      chk(8'({busPins.memIoSelOe, busPins.storeStrobeOe,
         busPins.xcvrDirectionOe, busPins.xcvrOutputEnableOe,
         busPins.addrLatchPulse}), 8'h0);
      holdOn = 1'b0;
      while (busPins.busYieldGrant && n < 40) begin
         @(negedge core_clk);
         n++;
      end
      bound(n);
      chk(8'(busPins.memIoSelOe), 8'h0);
      run_cycle(3'h3, 1'b0, 2'h1, 1'b0);
      $display("hold test done");
   endtask : test_hold
   task automatic test_max();
      logic [7:0] lat;
      do_reset(1'b0);
      lat = latchCnt;
      take(3'h1, 1'b0);
      repeat (12) @(negedge core_clk);
      chk(latchCnt - lat, 8'h0);
      chk(8'(busPins.memIoSelOe), 8'h0);
      do_reset(1'b1);
      $display("max mode test done");
   endtask : test_max
   initial begin
      do_reset(1'b1);
      test_queue();
      test_cycles();
      test_hold();
      test_max();
      end_of_test();
   end
endmodule : mmbc_bus_control_bench
